// ===== core/obs_pkg.sv
// How it works
// - After reset, pass start step, then line4=1, 5=0, 6=1, 7,8,9,14=0.
// - Step two drives lines 4-14 alternating 0,1 from line 4, waits power good.
// - Lines are open-drain: 0 leaves pin floating, 1 pulls pin to ground.
// - Step three drives 1 on even lines, 0 on odd lines, 4 through 14.
// - After step three pattern, wait 524.29 ms on timer 1.
// - Step five sets line 3 to 1, 0 on even lines, 1 on odd lines.
// - After step five pattern, wait 524.29 ms on timer 1 again.
// - After second wait, jump back to step three, repeat forever.
package obs_pkg;

  // ----------------------------------------
  // Lines and timing
  // ----------------------------------------
  localparam int          LINE_LO       = 3;
  localparam int          LINE_HI       = 14;
  localparam int          LINE_CNT      = LINE_HI - LINE_LO + 1;
  localparam int          CLK_MHZ       = 100;
  localparam real         WAIT_MS       = 524.29;
  localparam int          WAIT_CYCLES   = int'(WAIT_MS * 1000.0 * CLK_MHZ);
  localparam logic [11:0] LINES_RESET   = 12'h000;
  // Bit 0 is line 3, bit 11 is line 14
  localparam logic [11:0] PAT_STEP1     = 12'h00A;
  localparam logic [11:0] PAT_STEP2     = 12'h554;
  localparam logic [11:0] PAT_STEP3     = 12'hAAA;
  localparam logic [11:0] PAT_STEP5     = 12'h555;
  localparam logic [11:0] MASK_STEP1    = 12'h87E;
  localparam logic [11:0] MASK_STEP2    = 12'hFFE;
  localparam logic [11:0] MASK_STEP5    = 12'hFFF;

  // ----------------------------------------
  // Program steps
  // ----------------------------------------
  typedef enum logic [3:0] {
    OBS_START    = 4'h0,
    OBS_INIT     = 4'h1,
    OBS_WAIT_PG  = 4'h2,
    OBS_PAT_A    = 4'h3,
    OBS_WAIT_A   = 4'h4,
    OBS_PAT_B    = 4'h5,
    OBS_WAIT_B   = 4'h6,
    OBS_LOOP     = 4'h7,
    OBS_SHUTDOWN = 4'h8,
    OBS_HALT     = 4'h9
  } obs_step_t;

endpackage

// ===== core/obs_timer.sv
`timescale 1ns/1ps
module obs_timer #(
  parameter int COUNT = 52429000
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clk_en,
  // Control
  input  wire logic start,
  output logic      expired
);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [31:0] count;
  logic        running;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count   <= 32'h0000_0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (clk_en) begin
      expired <= 1'b0;
      if (start) begin
        count   <= 32'h0000_0000;
        running <= 1'b1;
      end else if (running) begin
        if (count == 32'(COUNT - 1)) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count <= count + 32'h0000_0001;
        end
      end
    end
  end

endmodule // obs_timer

// ===== core/obs_sequencer.sv
`timescale 1ns/1ps
module obs_sequencer #(
  parameter int WAIT_CYCLES = obs_pkg::WAIT_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Analog status pin
  input  wire logic        analog_power_good,
  // Open-drain lines 3 to 14, bit 0 is line 3
  output logic      [11:0] line_out,
  output logic      [11:0] line_oe,
  // Status
  output logic      [3:0]  step
);

  // ----------------------------------------
  // Power good synchroniser
  // ----------------------------------------
  logic pg_meta;
  logic pg_sync;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pg_meta <= 1'b0;
      pg_sync <= 1'b0;
    end else if (clk_en) begin
      pg_meta <= analog_power_good;
      pg_sync <= pg_meta;
    end
  end

  // ----------------------------------------
  // Timer
  // ----------------------------------------
  logic timer_start;
  logic timer_expired;

  obs_timer #(
    .COUNT (WAIT_CYCLES)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clk_en  (clk_en),
    .start   (timer_start),
    .expired (timer_expired)
  );

  // ----------------------------------------
  // Step machine
  // ----------------------------------------
  obs_pkg::obs_step_t state;
  obs_pkg::obs_step_t next_state;
  logic [11:0]        lines;

  always_comb begin
    next_state  = state;
    timer_start = 1'b0;
    case (state)
      obs_pkg::OBS_START: begin
        next_state = obs_pkg::OBS_INIT;
      end
      obs_pkg::OBS_INIT: begin
        next_state = obs_pkg::OBS_WAIT_PG;
      end
      obs_pkg::OBS_WAIT_PG: begin
        if (pg_sync) begin
          next_state = obs_pkg::OBS_PAT_A;
        end
      end
      obs_pkg::OBS_PAT_A: begin
        next_state  = obs_pkg::OBS_WAIT_A;
        timer_start = 1'b1;
      end
      obs_pkg::OBS_WAIT_A: begin
        if (timer_expired) begin
          next_state = obs_pkg::OBS_PAT_B;
        end
      end
      obs_pkg::OBS_PAT_B: begin
        next_state  = obs_pkg::OBS_WAIT_B;
        timer_start = 1'b1;
      end
      obs_pkg::OBS_WAIT_B: begin
        if (timer_expired) begin
          next_state = obs_pkg::OBS_LOOP;
        end
      end
      obs_pkg::OBS_LOOP: begin
        next_state = obs_pkg::OBS_PAT_A;
      end
      obs_pkg::OBS_SHUTDOWN: begin
        next_state = obs_pkg::OBS_HALT;
      end
      obs_pkg::OBS_HALT: begin
        next_state = obs_pkg::OBS_HALT;
      end
      default: begin
        next_state = obs_pkg::OBS_START;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= obs_pkg::OBS_START;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Output patterns
  // ----------------------------------------
  logic      [11:0] load_mask;
  logic      [11:0] load_pat;
  logic             load_lines;
  wire logic [11:0] next_lines;

  // Pattern and the lines it names for the OBS_INIT, OBS_WAIT_PG, OBS_PAT_A and OBS_PAT_B steps
  always_comb begin
    load_lines = 1'b1;
    load_mask  = 12'h000;
    load_pat   = 12'h000;
    case (state)
      obs_pkg::OBS_INIT: begin
        load_mask = obs_pkg::MASK_STEP1;
        load_pat  = obs_pkg::PAT_STEP1;
      end
      obs_pkg::OBS_WAIT_PG: begin
        load_mask = obs_pkg::MASK_STEP2;
        load_pat  = obs_pkg::PAT_STEP2;
      end
      obs_pkg::OBS_PAT_A: begin
        load_mask = obs_pkg::MASK_STEP2;
        load_pat  = obs_pkg::PAT_STEP3;
      end
      obs_pkg::OBS_PAT_B: begin
        load_mask = obs_pkg::MASK_STEP5;
        load_pat  = obs_pkg::PAT_STEP5;
      end
      default: begin
        load_lines = 1'b0;
      end
    endcase
  end

  // Named lines take the step pattern, the others keep their value
  generate
    for (genvar g = 0; g < obs_pkg::LINE_CNT; g++) begin : g_line
      assign next_lines[g] = (load_lines && load_mask[g]) ? load_pat[g] : lines[g];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lines <= obs_pkg::LINES_RESET;
    end else if (clk_en) begin
      lines <= next_lines;
    end
  end

  // ----------------------------------------
  // Open-drain drive
  // ----------------------------------------
  always_comb begin
    line_out = 12'h000;
    line_oe  = lines;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      step <= 4'h0;
    end else if (clk_en) begin
      step <= next_state;
    end
  end

endmodule // obs_sequencer

// ===== testbench/obs_assertions.sv
`timescale 1ns/1ps
module obs_assertions #(parameter int WAIT_CYCLES = 4) (
  // Sequencer ports
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        analog_power_good,
  input wire logic [11:0] line_out,
  input wire logic [11:0] line_oe,
  input wire logic [3:0]  step
);
  int cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Enabled cycles spent in a wait step
  always_ff @(posedge clk_sys)
    if (reset) cnt <= 0;
    else if (clk_en) cnt <= (step == 4'h4 || step == 4'h6) ? cnt + 1 : 0;
  sequence pg_held;
    (clk_en && analog_power_good && step == 4'h2) [*3];
  endsequence
  sequence pg_low;
    (clk_en && !analog_power_good) ##1 clk_en ##1 (clk_en && step == 4'h2);
  endsequence
  a_pg_start: assert property (pg_held |=> step == 4'h3)
    else $error("no start on power good");
  a_pg_hold: assert property (pg_low |=> step == 4'h2)
    else $error("left wait without power good");
  a_open_drain: assert property (line_out == 12'h000)
    else $error("line value driven high");
  a_init_pat: assert property (step == 4'h1 && clk_en |=> line_oe == 12'h00A)
    else $error("bad init pattern");
  a_alt_pat: assert property ($past(step == 4'h2 && clk_en) |-> line_oe == 12'h554)
    else $error("bad wait pattern");
  a_pat_a: assert property (step == 4'h4 |-> line_oe[11:1] == 11'h555)
    else $error("bad first loop pattern");
  a_pat_b: assert property (step == 4'h6 |-> line_oe == 12'h555)
    else $error("bad second loop pattern");
  a_wait_len: assert property ($changed(step) && (step == 4'h5 || step == 4'h7)
    |-> cnt == WAIT_CYCLES + 1) else $error("bad wait length");
  a_step_order: assert property ($changed(step)
    |-> step == (($past(step) == 4'h7) ? 4'h3 : $past(step) + 4'h1))
    else $error("bad step order");
endmodule // obs_assertions
bind obs_sequencer obs_assertions #(.WAIT_CYCLES(WAIT_CYCLES)) u_chk (.clk_sys, .reset,
  .clk_en, .analog_power_good, .line_out, .line_oe, .step);

// ===== testbench/obs_led_bank.sv
`timescale 1ns/1ps
module obs_led_bank (
  // Open-drain lines and lit indicators
  input  wire logic [11:0] line_out,
  input  wire logic [11:0] line_oe,
  output logic      [11:0] lit
);
  // Pulled-up pin lights its indicator only when sunk low
  assign lit = ~((line_oe & line_out) | ~line_oe);
endmodule // obs_led_bank

// ===== testbench/test_output_blink_sequencer.sv
`timescale 1ns/1ps
module test_output_blink_sequencer;
  logic        clk_sys = 0, reset = 1, clk_en = 1, pg = 0;
  logic [11:0] line_out, line_oe, lit, m_oe;
  logic [3:0]  step, last;
  localparam int T_WAIT = 4;
  int          failures = 0, cmp_count = 0, cyc = 0, seed = 32'h307EB1C7;
  int          en_cnt = 0, en_at = 0;
  obs_sequencer #(.WAIT_CYCLES(T_WAIT)) dut (.clk_sys, .reset, .clk_en,
    .analog_power_good(pg), .line_out, .line_oe, .step);
  obs_led_bank led (.line_out, .line_oe, .lit);
  initial forever #5 clk_sys = ~clk_sys;
  // Enabled edges, counted where clk_en is settled
  always @(posedge clk_sys) if (clk_en) en_cnt++;
  task chk(string n, logic [11:0] e, logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop_test;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Model checks every step change
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test;
    end else if (!reset && step !== last) begin
      chk("step", (last == 4'h7) ? 12'h003 : last + 12'h001, step);
      if (last == 4'h4 || last == 4'h6) begin
        chk("wait", 12'(T_WAIT + 1), 12'(en_cnt - en_at));
      end
      case (last)
        4'h1: m_oe = (m_oe & 12'h781) | 12'h00A;
        4'h2: m_oe = (m_oe & 12'h001) | 12'h554;
        4'h3: m_oe = (m_oe & 12'h001) | 12'hAAA;
        4'h5: m_oe = 12'h555;
        default: ;
      endcase
      chk("lines", m_oe, line_oe);
      chk("leds", m_oe, lit);
      last = step;
      en_at = en_cnt;
    end
  end
  initial begin
    for (int r = 0; r < 2; r++) begin
      reset = 1;
      clk_en = 1;
      pg = 0;
      last = 0;
      m_oe = 0;
      repeat (3) @(negedge clk_sys);
      chk("reset lines", 12'h000, line_oe);
      reset = 0;
      repeat (20 + {$random(seed)} % 8) @(negedge clk_sys);
      chk("idle step", 12'h002, {8'h00, step});
      pg = 1;
      repeat (300) @(negedge clk_sys) begin
        clk_en = ({$random(seed)} % 4) != 0;
        pg = ($random(seed) & 1) != 0;
      end
    end
    stop_test;
  end
endmodule // test_output_blink_sequencer
